// ### core/printer_parallel_port_epp.sv
// Overview of operation
// - EPP: data strobe held through data accesses
// - EPP: address strobe held through address accesses
// - EPP: write indicator high on writes only
// - EPP: wait input stretches the current cycle
// - EPP: acknowledge pin is peripheral interrupt request
// - Standard: strobe pulse latches the data byte
// - Standard: line feed request drives its pin
// - Standard: select request drives select pin
// - Init request pulses printer reset output
// - Unidirectional: latch write pulse per write
// - Bidirectional: latch enable is data-port decode
// - Bidirectional: buffer enable on outgoing data
`default_nettype none
module printer_parallel_port_epp #(
	parameter int                         DEPTH      = printer_port_pkg::FIFO_DEPTH,
	parameter logic [printer_port_pkg::CNT_W-1:0] SETUP_CYC  = printer_port_pkg::SETUP_CYC,
	parameter logic [printer_port_pkg::CNT_W-1:0] STROBE_CYC = printer_port_pkg::STROBE_CYC,
	parameter logic [printer_port_pkg::CNT_W-1:0] HOLD_CYC   = printer_port_pkg::HOLD_CYC,
	parameter logic [printer_port_pkg::CNT_W-1:0] INIT_CYC   = printer_port_pkg::INIT_CYC
) (
	input  wire logic                    ref_clk,
	input  wire logic                    rst,
	input  wire logic                    portEnable,
	input  wire logic                    eppMode,
	input  wire logic                    bidirCfg,
	input  wire logic                    autoLfReq,
	input  wire logic                    selectReq,
	input  wire logic                    initReq,
	input  wire logic                    cmdValid,
	input  wire printer_port_pkg::cmd_t  cmdIn,
	output var  logic                    cmdReady,
	output var  logic                    rdValid,
	output var  logic [7:0]              rdData,
	output var  printer_port_pkg::status_t statusOut,
	output var  logic                    irqPulse,
	input  wire logic                    host_confirm_in,
	input  wire logic                    busyIn,
	input  wire logic                    errorIn,
	input  wire logic                    media_empty_in,
	input  wire logic                    online_status_in,
	input  wire logic [7:0]              pdIn,
	output var  logic [7:0]              pdOut,
	output var  logic                    pdOe,
	output var  logic                    auto_linefeed_out,
	output var  logic                    device_select_out,
	output var  logic                    data_latch_strobe,
	output var  logic                    printer_reset_out,
	output var  logic                    ext_latch_write_en,
	output var  logic                    ext_buffer_out_en
);
	localparam int CW = printer_port_pkg::CNT_W;

	logic [printer_port_pkg::SYNC_W-1:0] sync1_ff;
	logic [printer_port_pkg::SYNC_W-1:0] sync2_ff;
	logic                       hostPrev_ff;
	logic                       enable_ff;
	logic                       cfgEpp_ff;
	logic                       cfgBidir_ff;
	printer_port_pkg::state_t   state_ff;
	printer_port_pkg::state_t   nxt_state;
	logic [CW-1:0]              cnt_ff;
	logic [CW-1:0]              nxt_cnt;
	logic [CW-1:0]              initCnt_ff;
	printer_port_pkg::cmd_t     cmd_ff;
	printer_port_pkg::cmd_t     fifoData;
	printer_port_pkg::cmd_t     curCmd;
	logic                       fifoValid;
	logic                       pop;
	logic                       capture;
	logic                       hostSync;
	logic                       busySync;
	logic                       curEpp;
	logic                       curBidir;
	logic                       active;
	logic                       strobeNow;
	logic                       isWr;
	logic                       isAddr;
	logic                       dataPort;

	param_fifo #(
		.WIDTH($bits(printer_port_pkg::cmd_t)),
		.DEPTH(DEPTH)
	) cmdFifo (
		.ref_clk (ref_clk),
		.rst     (rst),
		.inValid (cmdValid),
		.inReady (cmdReady),
		.inData  (cmdIn),
		.outValid(fifoValid),
		.outReady(pop),
		.outData (fifoData)
	);

	// Pin inputs pass two flip-flops
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= {host_confirm_in, busyIn, errorIn, media_empty_in,
				online_status_in, pdIn};
			sync2_ff <= sync1_ff;
		end
	end

	assign hostSync = sync2_ff[12];
	assign busySync = sync2_ff[11];

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			enable_ff <= 1'b0;
		end else begin
			enable_ff <= portEnable;
		end
	end

	// Access sequencer
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		pop       = 1'b0;
		capture   = 1'b0;
		case (state_ff)
			printer_port_pkg::ST_IDLE: begin
				if (enable_ff && fifoValid) begin
					pop       = 1'b1;
					nxt_state = printer_port_pkg::ST_SETUP;
					nxt_cnt   = SETUP_CYC - CW'(1);
				end
			end
			printer_port_pkg::ST_SETUP: begin
				if (cnt_ff == '0) begin
					nxt_state = printer_port_pkg::ST_STROBE;
					nxt_cnt   = STROBE_CYC - CW'(1);
				end else begin
					nxt_cnt = cnt_ff - CW'(1);
				end
			end
			printer_port_pkg::ST_STROBE: begin
				if (cnt_ff != '0) begin
					nxt_cnt = cnt_ff - CW'(1);
				end else if (cfgEpp_ff && busySync) begin
					nxt_state = printer_port_pkg::ST_EXTEND;
				end else begin
					capture   = 1'b1;
					nxt_state = printer_port_pkg::ST_HOLD;
					nxt_cnt   = HOLD_CYC - CW'(1);
				end
			end
			printer_port_pkg::ST_EXTEND: begin
				if (!busySync) begin
					capture   = 1'b1;
					nxt_state = printer_port_pkg::ST_HOLD;
					nxt_cnt   = HOLD_CYC - CW'(1);
				end
			end
			printer_port_pkg::ST_HOLD: begin
				if (cnt_ff == '0) begin
					nxt_state = printer_port_pkg::ST_IDLE;
				end else begin
					nxt_cnt = cnt_ff - CW'(1);
				end
			end
			default: begin
				nxt_state = printer_port_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_ff <= printer_port_pkg::ST_IDLE;
			cnt_ff   <= '0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cmd_ff      <= '0;
			cfgEpp_ff   <= 1'b0;
			cfgBidir_ff <= 1'b0;
		end else if (pop) begin
			cmd_ff      <= fifoData;
			cfgEpp_ff   <= eppMode;
			cfgBidir_ff <= bidirCfg;
		end
	end

	// Pin decode of the coming cycle
	assign curCmd    = pop ? fifoData : cmd_ff;
	assign curEpp    = (state_ff == printer_port_pkg::ST_IDLE) ? eppMode : cfgEpp_ff;
	assign curBidir  = (state_ff == printer_port_pkg::ST_IDLE) ? bidirCfg : cfgBidir_ff;
	assign active    = nxt_state != printer_port_pkg::ST_IDLE;
	assign strobeNow = nxt_state == printer_port_pkg::ST_STROBE ||
		nxt_state == printer_port_pkg::ST_EXTEND;
	assign isWr      = !curCmd.op[1];
	assign isAddr    = curCmd.op[0];
	assign dataPort  = !curEpp || !isAddr;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			data_latch_strobe <= 1'b0;
			auto_linefeed_out <= 1'b0;
			device_select_out <= 1'b0;
		end else if (curEpp) begin
			data_latch_strobe <= active && isWr;
			auto_linefeed_out <= strobeNow && !isAddr;
			device_select_out <= strobeNow && isAddr;
		end else begin
			data_latch_strobe <= strobeNow && isWr;
			auto_linefeed_out <= enable_ff && autoLfReq;
			device_select_out <= enable_ff && selectReq;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pdOe               <= 1'b0;
			ext_latch_write_en <= 1'b0;
			ext_buffer_out_en  <= 1'b0;
		end else begin
			pdOe <= active && isWr;
			if (curBidir) begin
				ext_latch_write_en <= active && dataPort;
				ext_buffer_out_en  <= active && isWr;
			end else begin
				ext_latch_write_en <= nxt_state == printer_port_pkg::ST_SETUP && isWr;
				ext_buffer_out_en  <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pdOut <= '0;
		end else if (pop) begin
			pdOut <= fifoData.data;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rdValid <= 1'b0;
			rdData  <= '0;
		end else begin
			rdValid <= capture && !isWr;
			if (capture && !isWr) rdData <= sync2_ff[7:0];
		end
	end

	// Printer initialisation pulse
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			printer_reset_out <= 1'b0;
			initCnt_ff        <= '0;
		end else if (initReq && enable_ff && !printer_reset_out) begin
			printer_reset_out <= 1'b1;
			initCnt_ff        <= INIT_CYC - CW'(1);
		end else if (initCnt_ff != '0) begin
			initCnt_ff <= initCnt_ff - CW'(1);
		end else begin
			printer_reset_out <= 1'b0;
		end
	end

	// Status pins by mode
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			statusOut   <= '0;
			hostPrev_ff <= 1'b0;
			irqPulse    <= 1'b0;
		end else begin
			hostPrev_ff        <= hostSync;
			statusOut.ack      <= !eppMode && hostSync;
			statusOut.busy     <= !eppMode && busySync;
			statusOut.fault    <= sync2_ff[10];
			statusOut.paperOut <= sync2_ff[9];
			statusOut.online   <= sync2_ff[8];
			statusOut.irq      <= eppMode && hostSync;
			irqPulse           <= eppMode && hostSync && !hostPrev_ff;
		end
	end

	// Checks
	logic [CW-1:0] strobeLen_ff;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) strobeLen_ff <= '0;
		else if (data_latch_strobe) strobeLen_ff <= strobeLen_ff + CW'(1);
		else strobeLen_ff <= '0;
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	AST_EPP_DATA_STROBE: assert property (
		state_ff == printer_port_pkg::ST_STROBE && cfgEpp_ff && !cmd_ff.op[0]
		|-> auto_linefeed_out) else $error("data strobe missing in EPP data access");
	AST_EPP_ADDR_STROBE: assert property (
		(state_ff == printer_port_pkg::ST_STROBE || state_ff == printer_port_pkg::ST_EXTEND)
		&& cfgEpp_ff && cmd_ff.op[0] |-> device_select_out) else $error("address strobe missing");
	AST_WRITE_IND: assert property (
		cfgEpp_ff && state_ff != printer_port_pkg::ST_IDLE && cmd_ff.op[1]
		|-> !data_latch_strobe) else $error("write indicator high on read");
	AST_WAIT_STRETCH: assert property (
		state_ff == printer_port_pkg::ST_EXTEND && busySync
		|=> state_ff == printer_port_pkg::ST_EXTEND) else $error("wait not honoured");
	AST_IRQ: assert property (
		eppMode && $rose(hostSync) |=> irqPulse) else $error("interrupt request lost");
	AST_STD_STROBE_WIDTH: assert property (
		$fell(data_latch_strobe) && !cfgEpp_ff |-> strobeLen_ff == STROBE_CYC)
		else $error("standard strobe width wrong");
	AST_INIT_WIDTH: assert property (
		initReq && enable_ff && !printer_reset_out |=> printer_reset_out [*4])
		else $error("init pulse too short");
	AST_QUIET: assert property (
		!enable_ff && state_ff == printer_port_pkg::ST_IDLE |=> !ext_latch_write_en
		&& !ext_buffer_out_en && !pdOe && !printer_reset_out)
		else $error("enable active while port disabled");
	AST_UNIDIR_LATCH: assert property (
		ext_latch_write_en && !cfgBidir_ff |-> pdOe) else $error("latch pulse without data");
	AST_BIDIR_BUF: assert property (
		ext_buffer_out_en |-> cfgBidir_ff && pdOe) else $error("buffer enable misused");

	CV_EPP_WAIT: cover property (state_ff == printer_port_pkg::ST_EXTEND);
	CV_STD_WRITE: cover property ($fell(data_latch_strobe) && !cfgEpp_ff);
	CV_READ: cover property (rdValid);
	CV_FIFO_FULL: cover property (!cmdReady);
endmodule // printer_parallel_port_epp
`default_nettype wire

// ### core/printer_port_pkg.sv
`default_nettype none
package printer_port_pkg;
	localparam int CLK_MHZ    = 100;
	localparam int CNT_W      = 8;
	localparam int DATA_W     = 8;
	localparam int FIFO_DEPTH = 16;
	localparam int SYNC_W     = 13;
	localparam int SETUP_NS   = 500;
	localparam int STROBE_NS  = 500;
	localparam int HOLD_NS    = 500;
	localparam int INIT_NS    = 2500;
	localparam logic [CNT_W-1:0] SETUP_CYC  = CNT_W'((SETUP_NS * CLK_MHZ + 999) / 1000);
	localparam logic [CNT_W-1:0] STROBE_CYC = CNT_W'((STROBE_NS * CLK_MHZ + 999) / 1000);
	localparam logic [CNT_W-1:0] HOLD_CYC   = CNT_W'((HOLD_NS * CLK_MHZ + 999) / 1000);
	localparam logic [CNT_W-1:0] INIT_CYC   = CNT_W'((INIT_NS * CLK_MHZ + 999) / 1000);

	typedef enum logic [1:0] {
		OP_WR_DATA = 2'b00,
		OP_WR_ADDR = 2'b01,
		OP_RD_DATA = 2'b10,
		OP_RD_ADDR = 2'b11
	} op_t;

	typedef struct packed {
		op_t               op;
		logic [DATA_W-1:0] data;
	} cmd_t;

	typedef struct packed {
		logic ack;
		logic busy;
		logic fault;
		logic paperOut;
		logic online;
		logic irq;
	} status_t;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_SETUP  = 3'b001,
		ST_STROBE = 3'b010,
		ST_EXTEND = 3'b011,
		ST_HOLD   = 3'b100
	} state_t;
endpackage
`default_nettype wire

// ### core/param_fifo.sv
`default_nettype none
module param_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic             inValid,
	output var  logic             inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0]    wrPtr_ff;
	logic [AW-1:0]    rdPtr_ff;
	logic [AW:0]      count_ff;
	logic [AW:0]      nxt_count;
	logic             push;
	logic             pop;

	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;
	assign outValid = count_ff != '0;
	assign outData  = mem_ff[rdPtr_ff];

	always_comb begin
		nxt_count = count_ff;
		if (push && !pop) begin
			nxt_count = count_ff + (AW+1)'(1);
		end else if (pop && !push) begin
			nxt_count = count_ff - (AW+1)'(1);
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			count_ff <= '0;
			inReady  <= 1'b1;
			wrPtr_ff <= '0;
			rdPtr_ff <= '0;
		end else begin
			count_ff <= nxt_count;
			inReady  <= nxt_count != (AW+1)'(DEPTH);
			if (push) wrPtr_ff <= wrPtr_ff + AW'(1);
			if (pop) rdPtr_ff <= rdPtr_ff + AW'(1);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (push) mem_ff[wrPtr_ff] <= inData;
	end
endmodule // param_fifo
`default_nettype wire

// ### testbench/epp_peripheral_model.sv
`default_nettype none
module epp_peripheral_model (
	input  wire logic       ref_clk,
	input  wire logic       eppMode,
	input  wire logic       strobeData,
	input  wire logic       strobeAddr,
	input  wire logic       pdOe,
	input  wire logic [7:0] pdOut,
	input  wire logic       printerBusy,
	input  wire logic [3:0] waitCyc,
	input  wire logic [7:0] rdByte,
	output var  logic       busyIn,
	output var  logic [7:0] pdIn
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] waitLeft = 4'h0;
	logic       strobeDly = 1'b0;
	logic [7:0] lastBus = 8'h00;
	wire logic  strobe = strobeData | strobeAddr;
	always @(posedge ref_clk) begin
		strobeDly <= strobe;
		if (eppMode && strobe && !strobeDly) // Wait on each new strobe in EPP
			waitLeft <= waitCyc;
		else if (waitLeft != 4'h0)
			waitLeft <= waitLeft - 4'h1;
		lastBus <= pdIn;
	end
	// Wait in EPP, printer busy status in standard
	always_comb busyIn = eppMode ? (waitLeft != 4'h0) : printerBusy;
	// Host drive, read byte under a read strobe, else a changing pattern
	always_comb pdIn = pdOe ? pdOut : ((eppMode && strobe) ? rdByte : ~lastBus);
endmodule // epp_peripheral_model
`default_nettype wire

// ### testbench/printer_parallel_port_epp_tb_top.sv
`default_nettype none
module printer_parallel_port_epp_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int S  = 2;
	localparam int T  = 4;
	localparam int H  = 2;
	localparam int IC = 4;
	localparam int A  = S + T + H;
	logic ref_clk = 1'b0, rst = 1'b1, portEnable = 1'b0, eppMode = 1'b0, bidirCfg = 1'b0;
	logic autoLfReq = 1'b0, selectReq = 1'b0, initReq = 1'b0, cmdValid = 1'b0;
	logic host_confirm_in = 1'b0, errorIn = 1'b0, media_empty_in = 1'b0;
	logic online_status_in = 1'b0, printerBusy = 1'b0;
	logic [3:0] waitCyc = 4'h0;
	logic [7:0] rdByte = 8'h00, seenOut = 8'h00;
	printer_port_pkg::cmd_t    cmdIn = '0;
	printer_port_pkg::status_t statusOut;
	logic [7:0] rdData, pdIn, pdOut;
	logic cmdReady, rdValid, irqPulse, busyIn, pdOe, auto_linefeed_out, device_select_out;
	logic data_latch_strobe, printer_reset_out, ext_latch_write_en, ext_buffer_out_en;
	int cnt[9];
	int n_fail = 0;
	int check_count = 0;
	int cyc = 0;
	always #5 ref_clk = ~ref_clk;
	printer_parallel_port_epp #(.DEPTH(16), .SETUP_CYC(8'(S)), .STROBE_CYC(8'(T)),
		.HOLD_CYC(8'(H)), .INIT_CYC(8'(IC))) dut_u (
		.ref_clk(ref_clk), .rst(rst), .portEnable(portEnable), .eppMode(eppMode),
		.bidirCfg(bidirCfg), .autoLfReq(autoLfReq), .selectReq(selectReq),
		.initReq(initReq), .cmdValid(cmdValid), .cmdIn(cmdIn), .cmdReady(cmdReady),
		.rdValid(rdValid), .rdData(rdData), .statusOut(statusOut), .irqPulse(irqPulse),
		.host_confirm_in(host_confirm_in), .busyIn(busyIn), .errorIn(errorIn),
		.media_empty_in(media_empty_in), .online_status_in(online_status_in),
		.pdIn(pdIn), .pdOut(pdOut), .pdOe(pdOe), .auto_linefeed_out(auto_linefeed_out),
		.device_select_out(device_select_out), .data_latch_strobe(data_latch_strobe),
		.printer_reset_out(printer_reset_out), .ext_latch_write_en(ext_latch_write_en),
		.ext_buffer_out_en(ext_buffer_out_en));
	epp_peripheral_model peer_u (
		.ref_clk(ref_clk), .eppMode(eppMode), .strobeData(auto_linefeed_out),
		.strobeAddr(device_select_out), .pdOe(pdOe), .pdOut(pdOut),
		.printerBusy(printerBusy), .waitCyc(waitCyc), .rdByte(rdByte),
		.busyIn(busyIn), .pdIn(pdIn));
	task automatic test_done;
		if (n_fail == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			test_done();
		end
	end
	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			$display("MISMATCH %s expected %0h seen %0h", nm, e, g);
			n_fail++;
		end
	endtask
	// Counts high cycles of nine outputs over a window
	task automatic sample(input int win);
		logic [8:0] p;
		foreach (cnt[j]) cnt[j] = 0;
		repeat (win) begin
			p = {printer_reset_out, irqPulse, auto_linefeed_out, device_select_out,
				data_latch_strobe, pdOe, ext_latch_write_en, ext_buffer_out_en, rdValid};
			foreach (cnt[j]) if (p[j] === 1'b1) cnt[j]++;
			if (pdOe === 1'b1) seenOut = pdOut;
			@(negedge ref_clk);
		end
	endtask
	task automatic acc(input logic [1:0] op, input logic [7:0] d, input int win);
		@(negedge ref_clk);
		while (cmdReady !== 1'b1) @(negedge ref_clk);
		cmdIn = {op, d};
		cmdValid = 1'b1;
		@(negedge ref_clk);
		cmdValid = 1'b0;
		sample(win);
	endtask
	task automatic t_fifo;
		for (int i = 0; i < 17; i++) begin
			@(negedge ref_clk);
			if (i == 16) check("fullReady", 0, cmdReady);
			cmdIn = {2'b00, 8'(i)};
			cmdValid = 1'b1;
		end
		@(negedge ref_clk);
		cmdValid = 1'b0;
		sample(6);
		check("quietDisabled", 0, cnt[4] + cnt[3] + cnt[2]);
		portEnable = 1'b1;
		sample(16 * (A + 1) + 20);
		check("drainStrobes", 16 * T, cnt[4]);
		check("drainReady", 1, cmdReady);
	endtask
	task automatic t_std;
		logic [4:0] pat;
		acc(2'b00, 8'ha7, 30);
		check("stdStrobe", T, cnt[4]);
		check("stdBus", 8'ha7, seenOut);
		check("stdLatchWr", S, cnt[2]);
		check("stdOe", A, cnt[3]);
		check("stdBuf", 0, cnt[1]);
		bidirCfg = 1'b1;
		acc(2'b00, 8'h5c, 30);
		check("stdBidirLatch", A, cnt[2]);
		check("stdBidirBuf", A, cnt[1]);
		check("stdBidirBus", 8'h5c, seenOut);
		bidirCfg = 1'b0;
		acc(2'b10, 8'h00, 30);
		check("stdReadStrobe", 0, cnt[4]);
		autoLfReq = 1'b1;
		selectReq = 1'b1;
		repeat (4) @(negedge ref_clk);
		check("lineFeed", 1, auto_linefeed_out);
		check("select", 1, device_select_out);
		autoLfReq = 1'b0;
		selectReq = 1'b0;
		for (int k = 0; k < 2; k++) begin
			pat = k[0] ? 5'b01010 : 5'b10101;
			{host_confirm_in, printerBusy, errorIn, media_empty_in, online_status_in} = pat;
			repeat (6) @(negedge ref_clk);
			check("status", {pat, 1'b0}, statusOut);
		end
		{host_confirm_in, printerBusy, errorIn, media_empty_in, online_status_in} = 5'h00;
	endtask
	task automatic t_epp;
		logic [1:0] op;
		eppMode = 1'b1;
		for (int b = 0; b < 2; b++) begin
			for (int i = 0; i < 4; i++) begin
				op = 2'(i);
				bidirCfg = b[0];
				rdByte = 8'hc3 ^ 8'(i);
				acc(op, 8'h5a + 8'(i), 30);
				check("dataStrobe", !op[0] ? T : 0, cnt[6]);
				check("addrStrobe", op[0] ? T : 0, cnt[5]);
				check("writeFlag", !op[1] ? A : 0, cnt[4]);
				check("latchWr", b ? (!op[0] ? A : 0) : (!op[1] ? S : 0), cnt[2]);
				check("bufEn", (b && !op[1]) ? A : 0, cnt[1]);
				check("rdPulse", op[1] ? 1 : 0, cnt[0]);
				if (op[1]) check("rdData", rdByte, rdData);
			end
		end
		bidirCfg = 1'b0;
	endtask
	task automatic t_wait;
		waitCyc = 4'h6;
		acc(2'b00, 8'h3c, 40);
		waitCyc = 4'h0;
		check("waitStretch", 1, cnt[6] > T && cnt[6] <= T + 9);
		check("waitWrite", cnt[6] + S + H, cnt[4]);
	endtask
	task automatic t_irq;
		@(negedge ref_clk);
		host_confirm_in = 1'b1;
		sample(8);
		check("irqPulse", 1, cnt[7]);
		check("irqStatus", 1, statusOut.irq);
		host_confirm_in = 1'b0;
		sample(4);
	endtask
	task automatic t_init;
		@(negedge ref_clk);
		initReq = 1'b1;
		@(negedge ref_clk);
		initReq = 1'b0;
		sample(12);
		check("initPulse", IC, cnt[8]);
	endtask
	initial begin
		repeat (5) @(posedge ref_clk);
		@(negedge ref_clk);
		rst = 1'b0;
		check("idlePins", 0, {auto_linefeed_out, device_select_out, data_latch_strobe,
			printer_reset_out, ext_latch_write_en, ext_buffer_out_en, pdOe});
		check("resetReady", 1, cmdReady);
		t_fifo();
		t_std();
		t_epp();
		t_wait();
		t_irq();
		t_init();
		test_done();
	end
endmodule // printer_parallel_port_epp_tb_top
`default_nettype wire
